// ---- pcs_pkg.sv ----
package pcs_pkg;

  // Output counts
  localparam int NUM_BUS_CLK = 5;
  localparam int NUM_LCL_CLK = 3;

  // Register byte offsets
  localparam logic [7:0] OFS_OUT_CLK_CTRL = 8'h00;
  localparam logic [7:0] OFS_LCL_CLK_CTRL = 8'h04;
  localparam logic [7:0] OFS_RST_CFG_LOW = 8'h08;
  localparam logic [7:0] OFS_SYS_CLK_CTRL = 8'h0c;
  localparam logic [7:0] OFS_CLK_STATUS = 8'h10;

  // Local divide select codes
  localparam logic [1:0] DIV_BY_2 = 2'h0;
  localparam logic [1:0] DIV_BY_4 = 2'h1;

  // Field positions
  localparam int RCW_RATIO_BIT = 0;
  localparam int STAT_HOST_BIT = 0;
  localparam int STAT_HALVE_BIT = 1;
  localparam int STAT_READY_BIT = 2;
  localparam int SCC_WIDTH = 6;

  // Reset values
  localparam logic [31:0] RCW_RESET = 32'h0000_0000;
  localparam logic [1:0] DIV_RESET = 2'h0;

  // APB bus signals from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } pcs_apb_req_t;

  // Whole block state
  typedef struct packed {
    logic cfg_done;
    logic host;
    logic halve;
    logic prev_pri;
    logic half;
    logic prev_sync;
    logic [NUM_BUS_CLK-1:0] sel_eff;
    logic [NUM_BUS_CLK-1:0] bus_out;
    logic sync_out;
    logic csb_tick;
    logic lbiu_tick;
    logic ddr_strobe;
    logic [2:0] lcnt;
    logic [NUM_LCL_CLK-1:0] lclk;
    logic [NUM_BUS_CLK-1:0] occ;
    logic [1:0] div;
    logic [31:0] rcw;
    logic [SCC_WIDTH-1:0] scc;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } pcs_state_t;

endpackage

// ---- pcs_clock_ctrl.sv ----
`timescale 1ns/100ps
// How it works
// - primary clock chosen by host/agent mode
// - host mode uses reference, halved and muxed
// - strap picks sync output full or halved
// - per-output select picks full or halved
// - internal ticks follow returned sync input
// - agent mode uses bus clock, ignores reference
// - DDR strobe on both memory clock edges
// - local bus clock divided by 2/4/8
// - local unit clock 1x or 2x bus
module pcs_clock_ctrl
  import pcs_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Straps
  input wire logic host_mode_strap,
  input wire logic sync_out_halve_strap,
  // Clock inputs, sampled as levels
  input wire logic primary_ref_in,
  input wire logic bus_clock_in,
  input wire logic sync_loop_in,
  // Clock outputs
  output logic sync_loop_out,
  output logic [NUM_BUS_CLK-1:0] bus_clock_outputs,
  output logic [NUM_LCL_CLK-1:0] local_bus_clock_out,
  output logic csb_clock_tick,
  output logic local_unit_tick,
  output logic ddr_data_strobe,
  // Module clock modes for consumers
  output logic [SCC_WIDTH-1:0] system_clock_control,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // Registered state and its next value
  pcs_state_t st;
  pcs_state_t next_st;
  pcs_apb_req_t req;

  // Decoded inputs
  logic pri;
  logic pri_rise;
  logic sync_rise;
  logic sync_edge;
  logic setup;
  logic access;

  // Reset image of all state
  localparam pcs_state_t ST_RESET = '{
    rcw: RCW_RESET,
    div: DIV_RESET,
    default: '0
  };

  // Bundle the bus inputs
  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

  // Address decode shared by read and write
  function automatic logic is_mapped(input logic [7:0] a);
    return (a == OFS_OUT_CLK_CTRL) || (a == OFS_LCL_CLK_CTRL) || (a == OFS_RST_CFG_LOW)
        || (a == OFS_SYS_CLK_CTRL) || (a == OFS_CLK_STATUS);
  endfunction

  // Divider tap for a divide select code
  function automatic logic divider_tap(input logic [1:0] sel, input logic [2:0] cnt);
    case (sel)
      DIV_BY_2: return cnt[0];
      DIV_BY_4: return cnt[1];
      default: return cnt[2];
    endcase
  endfunction

  // Read data of a register, zero where unmapped
  function automatic logic [31:0] read_word(input pcs_state_t s, input logic [7:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      OFS_OUT_CLK_CTRL: w[NUM_BUS_CLK-1:0] = s.occ;
      OFS_LCL_CLK_CTRL: w[1:0] = s.div;
      OFS_RST_CFG_LOW: w = s.rcw;
      OFS_SYS_CLK_CTRL: w[SCC_WIDTH-1:0] = s.scc;
      // Host and halve bits come from the captured straps, ready from cfg_done
      OFS_CLK_STATUS: begin
        w[STAT_HOST_BIT] = s.host;
        w[STAT_HALVE_BIT] = s.halve;
        w[STAT_READY_BIT] = s.cfg_done;
      end
      default: ;
    endcase
    return w;
  endfunction

  // Primary source and edge detection
  always_comb begin
    pri = st.host ? primary_ref_in : bus_clock_in;
    pri_rise = pri && !st.prev_pri;
    sync_rise = sync_loop_in && !st.prev_sync;
    sync_edge = sync_loop_in != st.prev_sync;
    // Bus phases: setup, then access with answer standing
    setup = req.psel && !req.penable;
    access = req.psel && req.penable && st.pready;
  end

  // Next state
  always_comb begin
    // Hold all state by default
    next_st = st;
    // Answer pulses last one cycle
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;

    // capture straps after reset release
    // Straps read once, later strap changes ignored
    if (!st.cfg_done) begin
      next_st.cfg_done = 1'b1;
      next_st.host = host_mode_strap;
      next_st.halve = sync_out_halve_strap;
      next_st.sel_eff = st.occ;
    end else begin
      // Last sampled levels for edge detection
      next_st.prev_pri = pri;
      next_st.prev_sync = sync_loop_in;

      // fixed halving divider
      // Toggles on each primary rising edge
      if (pri_rise) begin
        next_st.half = !st.half;
      end

      next_st.sync_out = st.halve ? next_st.half : pri;

      // per-output mux, select adopted while both sources low
      // Switching while both are low avoids a runt pulse
      for (int i = 0; i < NUM_BUS_CLK; i++) begin
        if (!pri && !st.half) begin
          next_st.sel_eff[i] = st.occ[i];
        end
        next_st.bus_out[i] = next_st.sel_eff[i] ? next_st.half : pri;
      end

      // internal bus tick aligned to sync input
      next_st.csb_tick = sync_rise;
      // local unit at 1x or 2x bus rate
      next_st.lbiu_tick = st.rcw[RCW_RATIO_BIT] ? sync_edge : sync_rise;
      // data moves on both memory clock edges
      next_st.ddr_strobe = sync_edge;

      // local bus divide by 2, 4 or 8
      // Counter steps on each local unit tick
      if (st.lbiu_tick) begin
        next_st.lcnt = st.lcnt + 3'h1;
      end
      // All outputs take the same tap
      for (int j = 0; j < NUM_LCL_CLK; j++) begin
        next_st.lclk[j] = divider_tap(st.div, st.lcnt);
      end
    end

    // APB setup cycle: decode, answer in access cycle
    if (setup) begin
      next_st.pready = 1'b1;
      next_st.pslverr = !is_mapped(req.paddr);
      next_st.prdata = req.pwrite ? 32'h0000_0000 : read_word(st, req.paddr);
    end

    // APB access cycle: write lands as ready is seen
    if (access && req.pwrite) begin
      case (req.paddr)
        OFS_OUT_CLK_CTRL: next_st.occ = req.pwdata[NUM_BUS_CLK-1:0];
        OFS_LCL_CLK_CTRL: next_st.div = req.pwdata[1:0];
        OFS_RST_CFG_LOW: next_st.rcw = req.pwdata;
        OFS_SYS_CLK_CTRL: next_st.scc = req.pwdata[SCC_WIDTH-1:0];
        // Status and unmapped writes are dropped
        default: ;
      endcase
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (rst) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Clock outputs straight from state flops
  assign sync_loop_out = st.sync_out;
  assign bus_clock_outputs = st.bus_out;
  assign local_bus_clock_out = st.lclk;
  assign csb_clock_tick = st.csb_tick;
  assign local_unit_tick = st.lbiu_tick;
  assign ddr_data_strobe = st.ddr_strobe;

  // Register and bus outputs straight from state flops
  assign system_clock_control = st.scc;
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;

endmodule // pcs_clock_ctrl

// ---- pcs_partner.sv ----
`timescale 1ns/100ps
module pcs_partner (
  // Board side
  input wire logic mclk,
  input wire logic host,
  input wire logic sync_loop_out,
  // Clocks into the device
  output logic primary_ref_in,
  output logic bus_clock_in,
  output logic sync_loop_in
);
  logic [2:0] cnt = 3'h0;
  always @(posedge mclk) begin
    cnt <= cnt + 3'h1;
  end
  assign primary_ref_in = host & cnt[1];
  assign bus_clock_in = cnt[2];
  assign sync_loop_in = sync_loop_out;
endmodule // pcs_partner

// ---- pcs_monitor.sv ----
`timescale 1ns/100ps
module pcs_monitor (
  // Clock, reset, straps
  input wire logic mclk,
  input wire logic rst,
  input wire logic host_mode_strap,
  input wire logic sync_out_halve_strap,
  // Clock pins
  input wire logic primary_ref_in,
  input wire logic bus_clock_in,
  input wire logic sync_loop_in,
  input wire logic sync_loop_out,
  input wire logic csb_clock_tick,
  input wire logic local_unit_tick,
  input wire logic ddr_data_strobe,
  // Bus handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  chk_ddr_cause: assert property (
    ddr_data_strobe |-> $past(sync_loop_in) != $past(sync_loop_in, 2)) else $error("ddr cause");
  chk_ddr_edge: assert property (
    !$past(rst, 3) && $changed(sync_loop_in) |=> ddr_data_strobe) else $error("ddr edge");
  chk_csb_cause: assert property (
    csb_clock_tick |-> $past(sync_loop_in) && !$past(sync_loop_in, 2)) else $error("csb");
  chk_unit_cause: assert property (
    local_unit_tick |-> $past(sync_loop_in) != $past(sync_loop_in, 2)) else $error("unit");
  chk_sync_host: assert property (
    !$past(rst, 4) && host_mode_strap && !sync_out_halve_strap
    |-> sync_loop_out == $past(primary_ref_in)) else $error("sync host");
  chk_sync_agent: assert property (
    !$past(rst, 4) && !host_mode_strap && !sync_out_halve_strap
    |-> sync_loop_out == $past(bus_clock_in)) else $error("sync agent");
  chk_apb_answer: assert property (psel && !penable |=> pready) else $error("no ready");
  chk_apb_cause: assert property (pready |-> $past(psel) && !$past(penable)) else $error("ready");
  // Main scenarios
  cover property (local_unit_tick && !csb_clock_tick);
  cover property (!host_mode_strap && ddr_data_strobe);
  cover property (pready);
endmodule // pcs_monitor
bind pcs_clock_ctrl pcs_monitor mon_u (
  .mclk(mclk),
  .rst(rst),
  .host_mode_strap(host_mode_strap),
  .sync_out_halve_strap(sync_out_halve_strap),
  .primary_ref_in(primary_ref_in),
  .bus_clock_in(bus_clock_in),
  .sync_loop_in(sync_loop_in),
  .sync_loop_out(sync_loop_out),
  .csb_clock_tick(csb_clock_tick),
  .local_unit_tick(local_unit_tick),
  .ddr_data_strobe(ddr_data_strobe),
  .psel(psel),
  .penable(penable),
  .pready(pready)
);

// ---- testbench.sv ----
`timescale 1ns/100ps
module testbench;
  import pcs_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e; logic x;} pcs_row_t;
  logic mclk, rst, host_mode_strap, sync_out_halve_strap, primary_ref_in, bus_clock_in;
  logic sync_loop_in, sync_loop_out, csb_clock_tick, local_unit_tick, ddr_data_strobe;
  logic psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [NUM_BUS_CLK-1:0] bus_clock_outputs;
  logic [NUM_LCL_CLK-1:0] local_bus_clock_out;
  logic [SCC_WIDTH-1:0] system_clock_control;
  int err_total, num_checks, cyc, n[6];
  pcs_row_t rows[6] = '{'{OFS_OUT_CLK_CTRL, 32'hff, 32'h1f, 1'b0},
    '{OFS_LCL_CLK_CTRL, 32'hff, 32'h3, 1'b0}, '{OFS_RST_CFG_LOW, '1, '1, 1'b0},
    '{OFS_SYS_CLK_CTRL, 32'hff, 32'h3f, 1'b0}, '{OFS_CLK_STATUS, 32'hff, 32'h5, 1'b0},
    '{8'h14, 32'hff, 32'h0, 1'b1}};
  pcs_clock_ctrl dut_u (.mclk(mclk), .rst(rst), .host_mode_strap(host_mode_strap),
    .sync_out_halve_strap(sync_out_halve_strap), .primary_ref_in(primary_ref_in),
    .bus_clock_in(bus_clock_in), .sync_loop_in(sync_loop_in), .sync_loop_out(sync_loop_out),
    .bus_clock_outputs(bus_clock_outputs), .local_bus_clock_out(local_bus_clock_out),
    .csb_clock_tick(csb_clock_tick), .local_unit_tick(local_unit_tick),
    .ddr_data_strobe(ddr_data_strobe), .system_clock_control(system_clock_control),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  pcs_partner pm_u (.mclk, .host(host_mode_strap), .sync_loop_out, .primary_ref_in,
    .bus_clock_in, .sync_loop_in);
  initial begin
    mclk = 0;
    forever #10 mclk = ~mclk;
  end
  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 8000) begin
      err_total++;
      wrap_up();
    end
  end
  task automatic chk(input string s, input logic [31:0] v, input logic [31:0] e);
    num_checks++;
    if (v !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", s, e, v);
    end
  endtask
  task automatic near(input string s, input int v, input int e);
    chk(s, (v >= e - 1 && v <= e + 1) ? e : v, e);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk) penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge mclk);
  endtask
  task automatic meas(input int t);
    logic [2:0] p;
    n = '{default: 0};
    p = {bus_clock_outputs[1:0], local_bus_clock_out[0]};
    repeat (t) begin
      @(posedge mclk);
      n[0] += csb_clock_tick;
      n[1] += local_unit_tick;
      n[2] += ddr_data_strobe;
      n[3] += local_bus_clock_out[0] & ~p[0];
      n[4] += bus_clock_outputs[0] & ~p[1];
      n[5] += bus_clock_outputs[1] & ~p[2];
      p = {bus_clock_outputs[1:0], local_bus_clock_out[0]};
    end
  endtask
  task automatic restart(input logic h);
    rst <= 1;
    host_mode_strap <= h;
    repeat (12) @(posedge mclk);
    rst <= 0;
    @(posedge mclk);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata, sync_out_halve_strap} <= '0;
    restart(1);
    foreach (rows[i]) begin
      apb(1, rows[i].a, rows[i].w);
      apb(0, rows[i].a, 0);
      chk("rdata", rd, rows[i].e);
      chk("slverr", {31'h0, er}, {31'h0, rows[i].x});
    end
    chk("scc out", 32'(system_clock_control), 32'h3f);
    $display("test registers done");
    apb(1, OFS_OUT_CLK_CTRL, 32'h2);
    meas(256);
    near("bus0", n[4], 64);
    near("bus1", n[5], 32);
    near("csb", n[0], 64);
    near("ddr", n[2], 128);
    near("unit", n[1], 128);
    near("lclk", n[3], 16);
    apb(1, OFS_RST_CFG_LOW, 0);
    for (int d = 0; d < 3; d++) begin
      apb(1, OFS_LCL_CLK_CTRL, 32'(d));
      meas(256);
      near("unit", n[1], 64);
      near("lclk", n[3], 32 >> d);
    end
    $display("test ratios done");
    restart(0);
    chk("reset outs", 32'({bus_clock_outputs, local_bus_clock_out, sync_loop_out, pready,
      csb_clock_tick, ddr_data_strobe}), 32'h0);
    apb(0, OFS_CLK_STATUS, 0);
    chk("status", rd, 32'h4);
    meas(256);
    near("ddr", n[2], 64);
    $display("test agent done");
    wrap_up();
  end
endmodule // testbench
